// *** src/sscr_pkg.sv ***
// Package of register offsets, field positions and timing counts for the status/control bank.
`default_nettype none

package sscr_pkg;
	// Register offsets on the single-wire bus register space.
	localparam logic [5:0] SSCR_ADDR_STATUS = 6'h04;
	localparam logic [5:0] SSCR_ADDR_CONTROL = 6'h05;
	// Status register field positions.
	localparam int SSCR_ST_SF1 = 0;
	localparam int SSCR_ST_FERR = 4;
	localparam int SSCR_ST_BERR = 7;
	// Control register field positions.
	localparam int SSCR_CT_RESET = 0;
	localparam int SSCR_CT_SHUTDOWN = 1;
	localparam int SSCR_CT_LOW_POWER_SELECT = 2;
	localparam int SSCR_CT_FUNC_EN = 4;
	// Reset values.
	localparam logic [15:0] SSCR_CONTROL_RESET = 16'h0000;
	localparam logic [7:0] SSCR_STATUS_RESET = 8'h00;
	// Length of the internal device reset operation, in clock cycles.
	localparam int SSCR_DEV_RESET_CYCLES = 4;
	// Phases of the device.
	typedef enum logic {
		SSCR_RUN,
		SSCR_RESETTING
	} sscr_phase_type;
endpackage

`default_nettype wire

// *** src/sscr_regs.sv ***
// Device status and control register bank of a single-wire sensor bus slave.
`timescale 1ns/100ps
`default_nettype none

module sscr_regs #(
	parameter int RESET_CYCLES = sscr_pkg::SSCR_DEV_RESET_CYCLES
) (
	input wire logic clk, // 20 MHz clock.
	input wire logic rst, // Asynchronous power-up reset, active high.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire logic reg_wr, // One-cycle write strobe from the bus engine.
	input wire logic reg_rd, // One-cycle read strobe from the bus engine.
	input wire logic reg_bcast, // Write was sent to the broadcast number.
	input wire logic [5:0] reg_addr, // Register offset of the access.
	input wire logic [15:0] reg_wdata, // Write data.
	input wire logic ack_error, // Pulse: no-acknowledge driven or seen.
	input wire logic func_error, // Pulse: temperature function error.
	input wire logic func_error_handled, // Pulse: function handled its error.
	output logic [15:0] reg_rdata, // Read data, valid with reg_rvalid.
	output logic reg_rvalid, // Pulse: read of a register held here.
	output logic dev_reset, // High while the device reset operation runs.
	output logic shutdown_active, // Device is in shutdown.
	output logic low_power_active, // Device runs in low-power mode.
	output logic func_run // Temperature function may run.
);
	import sscr_pkg::*;

	// Whole state of the block in one record.
	typedef struct packed {
		sscr_phase_type phase;
		logic [7:0] rst_cnt;
		logic ctl_reset;
		logic ctl_shutdown;
		logic ctl_low_power;
		logic ctl_func_en;
		logic ferr;
		logic berr;
		logic [15:0] rdata;
		logic rvalid;
		logic dev_reset;
		logic shutdown_active;
		logic low_power_active;
		logic func_run;
	} sscr_state_type;

	localparam logic [7:0] RST_LAST = 8'(RESET_CYCLES - 1);

	sscr_state_type st;
	sscr_state_type next_st;
	logic hit_status;
	logic hit_control;
	logic ctl_write;
	logic start_reset;

	// Address decode of the two registers held here.
	assign hit_status = (reg_addr == SSCR_ADDR_STATUS);
	assign hit_control = (reg_addr == SSCR_ADDR_CONTROL);
	// Both own-number and broadcast writes reach the control register.
	assign ctl_write = reg_wr && hit_control && (st.phase == SSCR_RUN);
	// Only a one in bit 0 starts a reset; a zero leaves operation alone.
	assign start_reset = ctl_write && reg_wdata[SSCR_CT_RESET];

	// Next-state logic. Events arriving during the reset operation are
	// dropped on purpose, since that operation aborts all activity.
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		unique case (st.phase)
			SSCR_RUN: begin
				// Function error flag: set wins over the handled clear.
				if (func_error) begin
					next_st.ferr = 1'b1;
				end else if (func_error_handled) begin
					next_st.ferr = 1'b0;
				end
				// Bus error flag: a new error wins over the read clear.
				if (ack_error) begin
					next_st.berr = 1'b1;
				end else if (reg_rd && hit_status) begin
					next_st.berr = 1'b0;
				end
				if (ctl_write) begin
					// Bits 1 and 0 always take the written value.
					next_st.ctl_reset = reg_wdata[SSCR_CT_RESET];
					next_st.ctl_shutdown = reg_wdata[SSCR_CT_SHUTDOWN];
					if (!reg_bcast) begin
						next_st.ctl_low_power = reg_wdata[SSCR_CT_LOW_POWER_SELECT];
						next_st.ctl_func_en = reg_wdata[SSCR_CT_FUNC_EN];
					end
				end
				if (start_reset) begin
					next_st.phase = SSCR_RESETTING;
					next_st.rst_cnt = 8'h00;
				end
			end
			SSCR_RESETTING: begin
				if (st.rst_cnt == RST_LAST) begin
					// Completion: every register back to default and bit 0
					// self-clears.
					next_st.phase = SSCR_RUN;
					next_st.ctl_reset = SSCR_CONTROL_RESET[SSCR_CT_RESET];
					next_st.ctl_shutdown = SSCR_CONTROL_RESET[SSCR_CT_SHUTDOWN];
					next_st.ctl_low_power = SSCR_CONTROL_RESET[SSCR_CT_LOW_POWER_SELECT];
					next_st.ctl_func_en = SSCR_CONTROL_RESET[SSCR_CT_FUNC_EN];
					next_st.ferr = SSCR_STATUS_RESET[SSCR_ST_FERR];
					next_st.berr = SSCR_STATUS_RESET[SSCR_ST_BERR];
				end else begin
					next_st.rst_cnt = st.rst_cnt + 8'h01;
				end
			end
		endcase
		// Reads are served in every phase; unimplemented bits read zero.
		// The function event flag lives in the function block, so bit 0 is zero.
		// Reads do not look at the enable bit, so function registers elsewhere
		// on the same engine stay reachable while it is clear.
		next_st.rdata = 16'h0000;
		if (reg_rd && hit_status) begin
			next_st.rdata[SSCR_ST_FERR] = st.ferr;
			next_st.rdata[SSCR_ST_BERR] = st.berr;
			next_st.rvalid = 1'b1;
		end else if (reg_rd && hit_control) begin
			next_st.rdata[SSCR_CT_RESET] = st.ctl_reset;
			next_st.rdata[SSCR_CT_SHUTDOWN] = st.ctl_shutdown;
			next_st.rdata[SSCR_CT_LOW_POWER_SELECT] = st.ctl_low_power;
			next_st.rdata[SSCR_CT_FUNC_EN] = st.ctl_func_en;
			next_st.rvalid = 1'b1;
		end
		// Mode outputs, shutdown taking precedence over low power.
		next_st.dev_reset = (next_st.phase == SSCR_RESETTING);
		next_st.shutdown_active = next_st.ctl_shutdown;
		next_st.low_power_active = next_st.ctl_low_power && !next_st.ctl_shutdown;
		// The function runs only when enabled, not shut down and not in reset.
		next_st.func_run = next_st.ctl_func_en && !next_st.ctl_shutdown
			&& (next_st.phase == SSCR_RUN);
	end

	// State register. The power-up reset is itself a device reset, loading
	// the defaults, so the device runs without a reset command.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{phase: SSCR_RUN, rst_cnt: 8'h00, rdata: 16'h0000, default: 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state flip-flops.
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign dev_reset = st.dev_reset;
	assign shutdown_active = st.shutdown_active;
	assign low_power_active = st.low_power_active;
	assign func_run = st.func_run;

	// Function error is caught in the next cycle.
	a_ferr_set: assert property (@(posedge clk) disable iff (rst)
		ce && func_error && st.phase == SSCR_RUN |=> st.ferr)
		else $error("function error flag not set after error");

	// Function error holds while nothing clears it.
	a_ferr_hold: assert property (@(posedge clk) disable iff (rst)
		ce && st.ferr && !func_error_handled && st.phase == SSCR_RUN |=> st.ferr)
		else $error("function error flag lost without a clear");

	// Bus error is caught in the next cycle.
	a_berr_set: assert property (@(posedge clk) disable iff (rst)
		ce && ack_error && st.phase == SSCR_RUN |=> st.berr)
		else $error("bus error flag not set after no-acknowledge");

	// A status read clears the bus error and reports its old value.
	a_berr_read_clear: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_status && !ack_error && st.phase == SSCR_RUN
		|=> !st.berr && reg_rvalid && reg_rdata[SSCR_ST_BERR] == $past(st.berr))
		else $error("status read did not clear or report bus error");

	// Broadcast writes leave the upper control bits alone.
	a_bcast_keep: assert property (@(posedge clk) disable iff (rst)
		ce && ctl_write && reg_bcast && !reg_wdata[SSCR_CT_RESET]
		|=> st.ctl_func_en == $past(st.ctl_func_en)
		&& st.ctl_low_power == $past(st.ctl_low_power)
		&& st.ctl_shutdown == $past(reg_wdata[SSCR_CT_SHUTDOWN]))
		else $error("broadcast write touched protected control bits");

	// Writing bit 0 starts the reset operation at once.
	a_reset_start: assert property (@(posedge clk) disable iff (rst)
		ce && start_reset |=> dev_reset && st.ctl_reset)
		else $error("reset bit write did not start device reset");

	// At the end of the reset operation everything is at its default.
	a_reset_done: assert property (@(posedge clk) disable iff (rst)
		$fell(dev_reset) |-> !st.ctl_reset && !st.ctl_func_en && !st.ctl_shutdown
		&& !st.ctl_low_power && !st.ferr && !st.berr && !func_run)
		else $error("device reset left a register off its default");

	// Shutdown keeps the function halted and overrides low power.
	a_shutdown_halt: assert property (@(posedge clk) disable iff (rst)
		shutdown_active |-> !func_run && !low_power_active)
		else $error("function active or low power during shutdown");

	// The function may run only with its enable set.
	a_func_enable: assert property (@(posedge clk) disable iff (rst)
		func_run |-> st.ctl_func_en && !dev_reset)
		else $error("function running while disabled");

	// Bits unimplemented in both registers (15:8, 6:5 and 3) are zero in every answered read.
	a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		reg_rvalid |-> reg_rdata[15:8] == 8'h00 && reg_rdata[6:5] == 2'h0
		&& reg_rdata[3] == 1'b0)
		else $error("unimplemented register bits read as one");

	// Status answers carry only the two flags; the event bit lives elsewhere.
	a_status_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_status |=> reg_rvalid && reg_rdata[15:8] == 8'h00
		&& reg_rdata[6:5] == 2'h0 && reg_rdata[3:0] == 4'h0)
		else $error("status read returned an unimplemented bit as one");

	// Control answers carry only bits 4, 2, 1 and 0.
	a_control_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_control |=> reg_rvalid && reg_rdata[15:5] == 11'h000
		&& reg_rdata[3] == 1'b0)
		else $error("control read returned an unimplemented bit as one");

	// The handled pulse clears the flag when no new error arrives with it.
	a_ferr_clear: assert property (@(posedge clk) disable iff (rst)
		ce && func_error_handled && !func_error && st.phase == SSCR_RUN |=> !st.ferr)
		else $error("function error flag not cleared after handling");

	// Without an error pulse the function error flag never rises.
	a_ferr_no_stray: assert property (@(posedge clk) disable iff (rst)
		ce && !st.ferr && !func_error |=> !st.ferr)
		else $error("function error flag rose without an error");

	// Without a no-acknowledge the bus error flag never rises.
	a_berr_no_stray: assert property (@(posedge clk) disable iff (rst)
		ce && !st.berr && !ack_error |=> !st.berr)
		else $error("bus error flag rose without a no-acknowledge");

	// Only a status read clears the bus error flag outside the reset operation.
	a_berr_hold: assert property (@(posedge clk) disable iff (rst)
		ce && st.berr && !(reg_rd && hit_status) && st.phase == SSCR_RUN |=> st.berr)
		else $error("bus error flag lost without a status read");

	// An own-number write with bit 0 clear updates bits 4, 2 and 1.
	a_own_write: assert property (@(posedge clk) disable iff (rst)
		ce && ctl_write && !reg_bcast && !reg_wdata[SSCR_CT_RESET]
		|=> st.ctl_func_en == $past(reg_wdata[SSCR_CT_FUNC_EN])
		&& st.ctl_low_power == $past(reg_wdata[SSCR_CT_LOW_POWER_SELECT])
		&& st.ctl_shutdown == $past(reg_wdata[SSCR_CT_SHUTDOWN]))
		else $error("own-number write not taken by the control register");

	// A broadcast write still reaches bits 1 and 0.
	a_bcast_accept: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && reg_bcast && hit_control && st.phase == SSCR_RUN
		|=> st.ctl_shutdown == $past(reg_wdata[SSCR_CT_SHUTDOWN])
		&& st.ctl_reset == $past(reg_wdata[SSCR_CT_RESET]))
		else $error("broadcast write not taken by the control register");

	// While the reset operation runs, writes and events change nothing.
	a_reset_frozen: assert property (@(posedge clk) disable iff (rst)
		st.phase == SSCR_RESETTING && st.rst_cnt != RST_LAST
		|=> $stable(st.ctl_shutdown) && $stable(st.ctl_low_power)
		&& $stable(st.ctl_func_en) && $stable(st.ferr) && $stable(st.berr))
		else $error("state changed while the reset operation ran");

	// The reset counter steps by one each enabled cycle until its last count.
	a_reset_count: assert property (@(posedge clk) disable iff (rst)
		ce && st.phase == SSCR_RESETTING && st.rst_cnt != RST_LAST
		|=> st.phase == SSCR_RESETTING && st.rst_cnt == $past(st.rst_cnt) + 8'h01)
		else $error("reset operation counter did not advance");

	// On its last count the operation ends and bit 0 clears itself.
	a_reset_end: assert property (@(posedge clk) disable iff (rst)
		ce && st.phase == SSCR_RESETTING && st.rst_cnt == RST_LAST
		|=> st.phase == SSCR_RUN && !st.ctl_reset && !dev_reset)
		else $error("reset operation did not end on its last count");

	// Bit 0 and the busy output both mark exactly the reset operation.
	a_busy_tracks: assert property (@(posedge clk) disable iff (rst)
		dev_reset == (st.phase == SSCR_RESETTING) && st.ctl_reset == dev_reset)
		else $error("reset bit or busy output out of step with the operation");

	// Mode outputs follow the control bits, shutdown masking low power.
	a_mode_outputs: assert property (@(posedge clk) disable iff (rst)
		shutdown_active == st.ctl_shutdown
		&& low_power_active == (st.ctl_low_power && !st.ctl_shutdown))
		else $error("mode outputs out of step with the control bits");

	// The function runs exactly when enabled, not shut down and not in reset.
	a_func_gate: assert property (@(posedge clk) disable iff (rst)
		func_run == (st.ctl_func_en && !st.ctl_shutdown && !dev_reset))
		else $error("function run output out of step with its gates");

	// Nothing is answered without a read of a register held here.
	a_no_stray_answer: assert property (@(posedge clk) disable iff (rst)
		ce && !(reg_rd && (hit_status || hit_control))
		|=> !reg_rvalid && reg_rdata == 16'h0000)
		else $error("answer given without a matching read");

	// Straight after the power-up reset the device is idle in active mode.
	a_powerup_clean: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> st.phase == SSCR_RUN && !dev_reset && !func_run
		&& !shutdown_active && !low_power_active && !reg_rvalid)
		else $error("device not at its defaults after power-up reset");

endmodule // sscr_regs

`default_nettype wire

// *** tb/sscr_master.sv ***
// Behavioural bus master that issues accesses to the status and control bank.
`timescale 1ns/100ps
`default_nettype none

module sscr_master (
	input wire logic clk, // Bus clock.
	output logic wr, // Write strobe.
	output logic rd, // Read strobe.
	output logic bcast, // Write goes to the broadcast number.
	output logic [5:0] addr, // Register offset.
	output logic [15:0] wdata // Write data.
);
	// The bus is idle at time zero.
	initial begin
		wr = 1'h0;
		rd = 1'h0;
		bcast = 1'h0;
		addr = 6'h3F;
		wdata = 16'hFFFF;
	end

	// One access: the request is raised after an edge and held until the capturing edge.
	// Released broadcast, address and data lines show inverted values so that stale data never looks valid.
	task automatic access(input logic w, input logic b, input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		bcast <= b;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h0;
		bcast <= !b;
		addr <= ~a;
		wdata <= ~d;
	endtask
endmodule // sscr_master
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the status and control register bank.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import sscr_pkg::*;
	logic clk, rst, ce, ack_error, func_error, func_error_handled;
	logic wr, rd, bcast, rvalid, dev_reset, shutdown_active, low_power_active, func_run;
	logic [5:0] addr;
	logic [15:0] wdata, rdata;
	int fail_count = 0, samples_checked = 0, ctrl = 0, n;
	int unsigned seed = 32'h2E6A, d;

	sscr_master m (.clk(clk), .wr(wr), .rd(rd), .bcast(bcast), .addr(addr), .wdata(wdata));
	sscr_regs dut (.clk(clk), .rst(rst), .ce(ce), .reg_wr(wr), .reg_rd(rd), .reg_bcast(bcast),
		.reg_addr(addr), .reg_wdata(wdata), .ack_error(ack_error), .func_error(func_error),
		.func_error_handled(func_error_handled), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.dev_reset(dev_reset), .shutdown_active(shutdown_active),
		.low_power_active(low_power_active), .func_run(func_run));

	// Free-running 20 MHz clock.
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Reads one offset and compares the answer, which stands only in the cycle after capture.
	task automatic read_reg(input logic [5:0] a, input logic [15:0] exp);
		m.access(1'h0, 1'h0, a, 16'h0000);
		#1;
		check("rvalid", {15'h0000, a inside {6'h04, 6'h05}}, {15'h0000, rvalid});
		check("rdata", exp, rdata);
	endtask

	// Mode outputs follow the model; shutdown masks the other two.
	task automatic check_mode();
		check("mode", {13'h0000, ctrl[4] & !ctrl[1], ctrl[2] & !ctrl[1], ctrl[1]},
			{13'h0000, func_run, low_power_active, shutdown_active});
	endtask

	// One-cycle event pulses as {ack_error, func_error, func_error_handled}.
	task automatic events(input logic [2:0] v);
		@(posedge clk);
		{ack_error, func_error, func_error_handled} <= v;
		@(posedge clk);
		{ack_error, func_error, func_error_handled} <= 3'h0;
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence: power-up state, control writes, flags, a device reset, then a power-up reset in mid-run.
	initial begin
		rst = 1'h1;
		ce = 1'h1;
		{ack_error, func_error, func_error_handled} = 3'h0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		read_reg(SSCR_ADDR_STATUS, 16'h0000);
		read_reg(SSCR_ADDR_CONTROL, 16'h0000);
		read_reg(6'h06, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			d = xs() & 32'hFFFE;
			m.access(1'h1, i[0], SSCR_ADDR_CONTROL, d[15:0]);
			ctrl = i[0] ? ((ctrl & 32'h14) | (d & 32'h2)) : (d & 32'h16);
			#1;
			check_mode();
			read_reg(SSCR_ADDR_CONTROL, ctrl[15:0]);
		end
		// A frozen clock enable must drop a write that differs in bits 4, 2 and 1, with bit 0 left at zero.
		@(posedge clk);
		ce <= 1'h0;
		m.access(1'h1, 1'h0, SSCR_ADDR_CONTROL, ~ctrl[15:0] & 16'hFFFE);
		#1;
		check_mode();
		@(posedge clk);
		ce <= 1'h1;
		read_reg(SSCR_ADDR_CONTROL, ctrl[15:0]);
		events(3'h2);
		read_reg(SSCR_ADDR_STATUS, 16'h0010);
		read_reg(SSCR_ADDR_STATUS, 16'h0010);
		events(3'h1);
		read_reg(SSCR_ADDR_STATUS, 16'h0000);
		events(3'h4);
		read_reg(SSCR_ADDR_STATUS, 16'h0080);
		read_reg(SSCR_ADDR_STATUS, 16'h0000);
		m.access(1'h1, 1'h0, SSCR_ADDR_CONTROL, 16'h0016);
		events(3'h6);
		m.access(1'h1, 1'h1, SSCR_ADDR_CONTROL, 16'h0001);
		#1;
		check("busy", 16'h0001, {15'h0000, dev_reset});
		check("halted", 16'h0000, {15'h0000, func_run});
		n = 0;
		// Bounded wait; a hang shows up as a wrong length.
		while (dev_reset === 1'h1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("reset length", 16'(SSCR_DEV_RESET_CYCLES), n[15:0]);
		ctrl = 0;
		check_mode();
		read_reg(SSCR_ADDR_CONTROL, 16'h0000);
		read_reg(SSCR_ADDR_STATUS, 16'h0000);
		// A power-up reset in mid-run must bring back every default.
		m.access(1'h1, 1'h0, SSCR_ADDR_CONTROL, 16'h0014);
		ctrl = 32'h14;
		events(3'h6);
		#1;
		check_mode();
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		ctrl = 0;
		#1;
		check_mode();
		read_reg(SSCR_ADDR_CONTROL, 16'h0000);
		read_reg(SSCR_ADDR_STATUS, 16'h0000);
		test_done();
	end
endmodule // testbench
`default_nettype wire
